// file: pkg/pfci_map.vh
/*
  Constant map for the parallel flash host controller: command codes,
  unlock offsets, identification offsets, status bit positions and
  bus timing counts at a 50 MHz core clock.
  Assumes a byte-wide flash with 17 address lines on the far side.
*/
`ifndef PFCI_MAP_VH
`define PFCI_MAP_VH

// ======================================================================
// Command codes and unlock offsets
`define PFCI_UNLOCK_ADDR_1 17'h00555
`define PFCI_UNLOCK_ADDR_2 17'h002AA
`define PFCI_UNLOCK_DATA_1 8'hAA
`define PFCI_UNLOCK_DATA_2 8'h55
`define PFCI_CMD_IDENT 8'h90
`define PFCI_CMD_PROGRAM 8'hA0
`define PFCI_CMD_ERASE_SETUP 8'h80
`define PFCI_CMD_CHIP_ERASE 8'h10
`define PFCI_CMD_SECTOR_ERASE 8'h30
`define PFCI_CMD_RESUME 8'h30
`define PFCI_CMD_SUSPEND 8'hB0
`define PFCI_CMD_RESET 8'hF0

// ======================================================================
// Identification offsets and sector field
`define PFCI_ID_DEVICE_OFS 17'h00001
`define PFCI_ID_PROTECT_OFS 17'h00002
`define PFCI_SECTOR_MSB 16
`define PFCI_SECTOR_LSB 12

// ======================================================================
// Status bits in a polled byte
`define PFCI_POLL_BIT 7
`define PFCI_TOGGLE_BIT 6
`define PFCI_TIME_LIMIT_BIT 5

// ======================================================================
// Bus timing (ns) and clock period
`define PFCI_CLK_PERIOD_NS 20
`define PFCI_ACCESS_NS 70
`define PFCI_GLITCH_NS 5
`define PFCI_WRITE_PULSE_NS 45
`define PFCI_READ_CYC ((`PFCI_ACCESS_NS + `PFCI_CLK_PERIOD_NS - 1) / `PFCI_CLK_PERIOD_NS)
`define PFCI_WE_CYC ((`PFCI_WRITE_PULSE_NS + `PFCI_CLK_PERIOD_NS - 1) / `PFCI_CLK_PERIOD_NS)
`define PFCI_GLITCH_CYC ((`PFCI_GLITCH_NS + `PFCI_CLK_PERIOD_NS - 1) / `PFCI_CLK_PERIOD_NS)

`endif

// file: design/pfci_seq_rom.v
/*
  Small command-sequence store: for each operation and step it returns
  the address and data of the bus write, registered.
  Assumes the main controller holds op and step steady for one cycle
  before it uses the data.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pfci_map.vh"

module pfci_seq_rom (
  // Clock and reset
  input wire clk_i,
  input wire reset_n_i,
  // Lookup
  input wire [2:0] op_i,
  input wire [2:0] step_i,
  input wire [16:0] user_addr_i,
  input wire [7:0] user_data_i,
  // Registered result
  output reg [16:0] addr_o,
  output reg [7:0] data_o
);

  // ======================================================================
  // Sequence table
  reg [16:0] a_next;
  reg [7:0] d_next;

  // Steps 0..1 are the unlock pair, later steps depend on the operation
  always @* begin
    a_next = user_addr_i;
    d_next = user_data_i;
    case (step_i)
      3'h0: begin
        a_next = `PFCI_UNLOCK_ADDR_1;
        d_next = `PFCI_UNLOCK_DATA_1;
      end
      3'h1: begin
        a_next = `PFCI_UNLOCK_ADDR_2;
        d_next = `PFCI_UNLOCK_DATA_2;
      end
      3'h2: begin
        a_next = `PFCI_UNLOCK_ADDR_1;
        case (op_i)
          3'h1: d_next = `PFCI_CMD_PROGRAM;
          3'h2, 3'h3: d_next = `PFCI_CMD_ERASE_SETUP;
          default: d_next = `PFCI_CMD_IDENT;
        endcase
      end
      3'h3: begin
        if (op_i != 3'h1) begin
          a_next = `PFCI_UNLOCK_ADDR_1;
          d_next = `PFCI_UNLOCK_DATA_1;
        end
      end
      3'h4: begin
        a_next = `PFCI_UNLOCK_ADDR_2;
        d_next = `PFCI_UNLOCK_DATA_2;
      end
      3'h5: begin
        if (op_i == 3'h2) begin
          a_next = `PFCI_UNLOCK_ADDR_1;
          d_next = `PFCI_CMD_CHIP_ERASE;
        end else begin
          d_next = `PFCI_CMD_SECTOR_ERASE;
        end
      end
      default: begin
        a_next = user_addr_i;
        d_next = user_data_i;
      end
    endcase
  end

  // Registered output keeps the pin data glitch free
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_o <= 17'h00000;
      data_o <= 8'h00;
    end else begin
      addr_o <= a_next;
      data_o <= d_next;
    end
  end

endmodule // pfci_seq_rom

`default_nettype wire

// file: design/pfci_host.v
/*
  Host controller for a byte-wide parallel flash: issues reads, unlock
  command sequences (program, chip/sector erase, identification),
  single-write commands (reset, suspend, resume) and polls completion.
  Assumes flash pins are sampled synchronously to CORE_CLK_I and the
  data bus is resolved outside from the output enable.
*/
// Notes on behaviour
// - Host writes reset when the time-limit flag is high or in ID mode; pfci_host does so only on an OP_RESET request.
// - High-voltage ID mode uses selector pins; no such voltage here.
// - ID entry: unlock pair, 90; device code at X01, protect at X02.
// - Valid write: chip select and write enable low, output enable high.
// - Each sequence opens with AA at 555 then 55 at 2AA.
// - Program: unlock pair, A0 at 555, data at the target.
// - Erase: unlock, 80, unlock, then 10 at 555 or 30 at sector.
// - Single writes F0 reset, B0 suspend, 30 resume, any address.
// - Host leaves ID mode by writing reset.
`timescale 1ns/1ps
`default_nettype none
`include "pfci_map.vh"

module pfci_host #(
  parameter ADDR_W = 17,
  parameter POLL_LIMIT = 32'd50000000
) (
  // Clock and reset
  input wire CORE_CLK_I,
  input wire RESET_N_I,
  // User request
  input wire REQ_VALID_I,
  input wire [3:0] REQ_OP_I,
  input wire [ADDR_W-1:0] REQ_ADDR_I,
  input wire [7:0] REQ_DATA_I,
  output wire REQ_READY_O,
  // User answer
  output reg DONE_O,
  output reg [7:0] RDATA_O,
  output reg ERROR_O,
  output reg ID_MODE_O,
  // Flash pins
  output reg FL_CE_N_O,
  output reg FL_OE_N_O,
  output reg FL_WE_N_O,
  output wire [ADDR_W-1:0] FL_ADDR_O,
  output wire [7:0] FL_DQ_O,
  output reg FL_DQ_OE_O,
  input wire [7:0] FL_DQ_I
);

  // ======================================================================
  // Operations and states
  localparam OP_READ = 4'h0;
  localparam OP_PROG = 4'h1;
  localparam OP_CHIP = 4'h2;
  localparam OP_SECT = 4'h3;
  localparam OP_IDENT = 4'h4;
  localparam OP_RESET = 4'h5;
  localparam OP_SUSP = 4'h6;
  localparam OP_RESUME = 4'h7;

  localparam ST_IDLE = 3'h0;
  localparam ST_SETUP = 3'h1;
  localparam ST_WRITE = 3'h2;
  localparam ST_GAP = 3'h3;
  localparam ST_READ = 3'h4;
  localparam ST_POLL = 3'h5;
  localparam ST_DONE = 3'h6;

  // Counts are worked out wide, then cut to the counter width
  localparam integer READ_CYC_W = `PFCI_READ_CYC;
  localparam integer WE_CYC_W = `PFCI_WE_CYC;
  localparam [3:0] READ_CYC = READ_CYC_W[3:0];
  localparam [3:0] WE_CYC = WE_CYC_W[3:0];

  // Number of bus writes each operation issues
  function [2:0] pfci_len;
    input [3:0] op;
    begin
      case (op)
        OP_PROG, OP_IDENT: pfci_len = 3'h3 + {2'b00, op == OP_PROG};
        OP_CHIP, OP_SECT: pfci_len = 3'h6;
        OP_RESET, OP_SUSP, OP_RESUME: pfci_len = 3'h1;
        default: pfci_len = 3'h0;
      endcase
    end
  endfunction

  reg [2:0] state_reg, state_next;
  reg [3:0] op_reg;
  reg [2:0] step_reg;
  reg [3:0] cnt_reg;
  reg [31:0] poll_cnt_reg;
  reg [ADDR_W-1:0] addr_reg;
  reg [7:0] data_reg;
  reg [7:0] last_poll_reg;
  reg id_mode_reg;
  wire [16:0] rom_addr;
  wire [7:0] rom_data;
  wire single_cmd;
  wire [2:0] rom_op;
  wire [2:0] rom_step;
  wire toggling;
  wire first_poll;

  assign REQ_READY_O = (state_reg == ST_IDLE);
  assign single_cmd = (op_reg == OP_RESET) || (op_reg == OP_SUSP) ||
                      (op_reg == OP_RESUME);
  // Single-write commands use the user byte and request address at step 6
  assign rom_op = op_reg[2:0];
  assign rom_step = single_cmd ? 3'h6 : step_reg;

  // ======================================================================
  // Sequence store
  pfci_seq_rom u_rom (
    .clk_i(CORE_CLK_I),
    .reset_n_i(RESET_N_I),
    .op_i(rom_op),
    .step_i(rom_step),
    .user_addr_i(addr_reg[16:0]),
    .user_data_i(data_reg),
    .addr_o(rom_addr),
    .data_o(rom_data)
  );

  // In a read, address goes straight from the request register
  assign FL_ADDR_O = (op_reg == OP_READ) ? addr_reg : rom_addr;
  assign FL_DQ_O = rom_data;
  // Polling toggle bit flips while an embedded operation runs
  assign toggling = (FL_DQ_I[`PFCI_TOGGLE_BIT] !=
                     last_poll_reg[`PFCI_TOGGLE_BIT]);
  // A stale byte from an earlier read can match by chance, so the
  // first status read of an operation only seeds the toggle history
  assign first_poll = (poll_cnt_reg == 32'h0);

  // ======================================================================
  // Next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (REQ_VALID_I) begin
        state_next = (REQ_OP_I == OP_READ) ? ST_READ : ST_SETUP;
      end
      ST_SETUP: state_next = ST_WRITE;
      ST_WRITE: if (cnt_reg == WE_CYC) begin
        state_next = ST_GAP;
      end
      ST_GAP: begin
        if (step_reg + 3'h1 < pfci_len(op_reg) && !single_cmd) begin
          state_next = ST_SETUP;
        end else if (op_reg == OP_PROG || op_reg == OP_CHIP ||
                     op_reg == OP_SECT) begin
          state_next = ST_POLL;
        end else begin
          state_next = ST_DONE;
        end
      end
      ST_READ: if (cnt_reg == READ_CYC) begin
        state_next = ST_DONE;
      end
      ST_POLL: if (cnt_reg == READ_CYC) begin
        if ((!first_poll && (!toggling ||
             FL_DQ_I[`PFCI_TIME_LIMIT_BIT])) ||
            poll_cnt_reg == POLL_LIMIT) begin
          state_next = ST_DONE;
        end else begin
          state_next = ST_POLL;
        end
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // ======================================================================
  // Datapath and pins
  always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_READ;
      step_reg <= 3'h0;
      cnt_reg <= 4'h0;
      poll_cnt_reg <= 32'h0;
      addr_reg <= {ADDR_W{1'b0}};
      data_reg <= 8'h00;
      last_poll_reg <= 8'h00;
      id_mode_reg <= 1'b0;
      FL_CE_N_O <= 1'b1;
      FL_OE_N_O <= 1'b1;
      FL_WE_N_O <= 1'b1;
      FL_DQ_OE_O <= 1'b0;
      DONE_O <= 1'b0;
      RDATA_O <= 8'h00;
      ERROR_O <= 1'b0;
      ID_MODE_O <= 1'b0;
    end else begin
      state_reg <= state_next;
      DONE_O <= 1'b0;
      ID_MODE_O <= id_mode_reg;
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= 4'h0;
          step_reg <= 3'h0;
          poll_cnt_reg <= 32'h0;
          FL_CE_N_O <= 1'b1;
          FL_OE_N_O <= 1'b1;
          FL_WE_N_O <= 1'b1;
          FL_DQ_OE_O <= 1'b0;
          if (REQ_VALID_I) begin
            op_reg <= REQ_OP_I;
            addr_reg <= REQ_ADDR_I;
            data_reg <= (REQ_OP_I == OP_RESET) ? `PFCI_CMD_RESET :
                        (REQ_OP_I == OP_SUSP) ? `PFCI_CMD_SUSPEND :
                        (REQ_OP_I == OP_RESUME) ? `PFCI_CMD_RESUME :
                        REQ_DATA_I;
            ERROR_O <= 1'b0;
          end
        end
        ST_SETUP: begin
          // Address settles a cycle before write enable falls
          cnt_reg <= 4'h0;
          FL_OE_N_O <= 1'b1;
          FL_CE_N_O <= 1'b0;
          FL_DQ_OE_O <= 1'b1;
        end
        ST_WRITE: begin
          // Pulse spans several clocks, far above the glitch floor
          FL_WE_N_O <= 1'b0;
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == WE_CYC) begin
            FL_WE_N_O <= 1'b1;
          end
        end
        ST_GAP: begin
          // Chip select rises after write enable so data latch is clean
          FL_CE_N_O <= 1'b1;
          FL_DQ_OE_O <= 1'b0;
          cnt_reg <= 4'h0;
          step_reg <= step_reg + 3'h1;
          // Flag only once the ident command itself has been written
          if (op_reg == OP_IDENT && step_reg == 3'h2) begin
            id_mode_reg <= 1'b1;
          end
          if (op_reg == OP_RESET) begin
            id_mode_reg <= 1'b0;
          end
        end
        ST_READ, ST_POLL: begin
          // Write enable stays high so a read never looks like a write
          FL_WE_N_O <= 1'b1;
          FL_CE_N_O <= 1'b0;
          FL_OE_N_O <= 1'b0;
          FL_DQ_OE_O <= 1'b0;
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == READ_CYC) begin
            cnt_reg <= 4'h0;
            RDATA_O <= FL_DQ_I;
            last_poll_reg <= FL_DQ_I;
            FL_OE_N_O <= 1'b1;
            if (state_reg == ST_POLL) begin
              poll_cnt_reg <= poll_cnt_reg + 32'h1;
              if (FL_DQ_I[`PFCI_TIME_LIMIT_BIT] && toggling &&
                  !first_poll) begin
                ERROR_O <= 1'b1;
              end
              if (poll_cnt_reg == POLL_LIMIT) begin
                ERROR_O <= 1'b1;
              end
            end
          end
        end
        ST_DONE: begin
          FL_CE_N_O <= 1'b1;
          FL_OE_N_O <= 1'b1;
          DONE_O <= 1'b1;
        end
        default: begin
          FL_CE_N_O <= 1'b1;
        end
      endcase
    end
  end

endmodule // pfci_host

`default_nettype wire

// file: dv/pfci_host_asserts.sv
/* Checker for the pfci_host pin and handshake timing.
   Assumes it is bound to pfci_host and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
// ========================
// Pin checker
module pfci_host_asserts #(
  parameter ADDR_W = 17
) (
  // Clock, reset and request side
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire logic REQ_VALID_I,
  input wire logic [3:0] REQ_OP_I,
  input wire logic REQ_READY_O,
  input wire logic DONE_O,
  input wire logic ID_MODE_O,
  // Flash pins
  input wire logic FL_CE_N_O,
  input wire logic FL_OE_N_O,
  input wire logic FL_WE_N_O,
  input wire logic [ADDR_W-1:0] FL_ADDR_O,
  input wire logic [7:0] FL_DQ_O,
  input wire logic FL_DQ_OE_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Accepted request
  wire take = REQ_VALID_I && REQ_READY_O;
  // Read: strobes low over the access window, answer two edges later
  sequence rd_walk_s;
    ##2 (!FL_CE_N_O && !FL_OE_N_O && FL_WE_N_O) [*4] ##2 DONE_O;
  endsequence
  // A strobe left low would let the part latch a stray command
  sequence we_up_s;
    ##1 !FL_WE_N_O ##[1:3] FL_WE_N_O;
  endsequence
  read_walk_a:
    assert property (take && REQ_OP_I == 4'h0 |-> rd_walk_s)
    else $error("read walk broken");
  we_pulse_a:
    assert property ($fell(FL_WE_N_O) |-> we_up_s)
    else $error("write strobe width wrong");
  write_qual_a:
    assert property (!FL_WE_N_O |-> !FL_CE_N_O && FL_OE_N_O && FL_DQ_OE_O)
    else $error("write strobe without qualifiers");
  no_contend_a:
    assert property (!FL_OE_N_O |-> !FL_DQ_OE_O)
    else $error("host drives while reading");
  standby_idle_a:
    assert property (FL_CE_N_O |-> !FL_DQ_OE_O && FL_WE_N_O && FL_OE_N_O)
    else $error("strobe active while deselected");
  wr_hold_a:
    assert property ($past(!FL_WE_N_O) |-> $stable(FL_ADDR_O) &&
      $stable(FL_DQ_O))
    else $error("address or data moved under strobe");
  unlock_first_a:
    assert property (take && REQ_OP_I inside {[4'h1:4'h4]} |-> ##[1:8]
      ($fell(FL_WE_N_O) && FL_ADDR_O == 17'h00555 && FL_DQ_O == 8'hAA))
    else $error("sequence does not open with unlock");
  id_enter_a:
    assert property (take && REQ_OP_I == 4'h4 |-> ##[1:40] ID_MODE_O)
    else $error("ident mode not flagged");
  id_exit_a:
    assert property (take && REQ_OP_I == 4'h5 |-> ##[1:16] !ID_MODE_O)
    else $error("ident mode not left on reset");
endmodule // pfci_host_asserts
bind pfci_host pfci_host_asserts #(.ADDR_W(ADDR_W)) chk_u (
  .CORE_CLK_I, .RESET_N_I, .REQ_VALID_I, .REQ_OP_I, .REQ_READY_O,
  .DONE_O, .ID_MODE_O, .FL_CE_N_O, .FL_OE_N_O, .FL_WE_N_O,
  .FL_ADDR_O, .FL_DQ_O, .FL_DQ_OE_O);
`default_nettype wire

// file: dv/pfci_fmodel.sv
/* Behavioural flash: command decoder, array and status bits.
   Assumes host strobes from pfci_host; clk times busy and latches the last driven byte. */
`timescale 1ns/1ps
`default_nettype none
// ========================
// Flash model
module pfci_fmodel #(
  parameter [4:0] PSEC = 5'h1F,
  parameter [7:0] DEVC = 8'h3C // Arbitrary value
) (
  // Timing clock and strobes
  input wire logic clk_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  // Makes the next program overrun its time limit
  input wire logic hang_i,
  // Address and data
  input wire logic [16:0] a_i,
  input wire logic [7:0] d_i,
  output logic [7:0] q_o
);
  logic [7:0] mem [0:131071];
  logic [7:0] pd, last_d, lq;
  logic [2:0] st;
  logic idm, busy, tlim, tog;
  int cnt, n_wr;
  wire rd_en = !ce_n_i && !oe_n_i;
  wire c5 = a_i == 17'h00555;
  wire u1 = c5 && d_i == 8'hAA;
  wire u2 = a_i == 17'h002AA && d_i == 8'h55;
  // selector address bits pick the identifier byte
  wire [7:0] idv = a_i[1:0] == 2'h1 ? DEVC : {7'h00, a_i[16:12] == PSEC};
  wire [7:0] stat = {~pd[7], tog, tlim, 5'h00};
  wire [7:0] arr = idm ? idv : mem[a_i];
  // Released bus shows the inverse of the last byte, not a held value
  assign q_o = rd_en ? (busy ? stat : arr) : ~lq;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {st, idm, busy, tlim, tog} = 7'h00;
    lq = 8'h00;
    n_wr = 0;
  end
  // Last driven byte, and the embedded operation timer
  always @(posedge clk_i) begin
    if (rd_en) lq <= q_o;
    if (busy && !tlim) begin
      if (cnt == 0) busy = 1'b0;
      else cnt = cnt - 1;
    end
  end
  always @(negedge oe_n_i) begin
    if (busy) tog = ~tog;
  end
  // Commands latch on the rising write strobe; OE low blocks them
  always @(posedge we_n_i) begin
    if (!ce_n_i && oe_n_i) begin
      n_wr = n_wr + 1;
      last_d = d_i;
      if (d_i == 8'hF0 && (!busy || tlim)) begin
        {st, idm, busy, tlim} = 6'h00;
      end else if (busy) begin
        st = 3'h0;
      end else begin
        case (st)
          3'h0: st = u1 ? 3'h1 : 3'h0;
          3'h1: st = u2 ? 3'h2 : 3'h0;
          3'h2: begin
            st = 3'h0;
            if (c5 && d_i == 8'h90) idm = 1'b1;
            if (c5 && d_i == 8'hA0) st = 3'h3;
            if (c5 && d_i == 8'h80) st = 3'h4;
          end
          3'h3: begin
            st = 3'h0;
            if (a_i[16:12] != PSEC) begin
              mem[a_i] = mem[a_i] & d_i;
              pd = d_i;
              tlim = hang_i;
              busy = 1'b1;
              cnt = 30;
            end
          end
          3'h4: st = u1 ? 3'h5 : 3'h0;
          3'h5: st = u2 ? 3'h6 : 3'h0;
          default: begin
            st = 3'h0;
            busy = (c5 && d_i == 8'h10) || d_i == 8'h30;
            pd = 8'hFF;
            cnt = 30;
            for (int i = 0; i < 131072; i++) begin
              if (busy && i[16:12] != PSEC && (d_i == 8'h10 ||
                i[16:12] == a_i[16:12])) mem[i] = 8'hFF;
            end
          end
        endcase
      end
    end
  end
endmodule // pfci_fmodel
`default_nettype wire

// file: dv/pfci_host_tb.sv
/* Self-checking bench for pfci_host driving a flash model.
   Assumes the model and checker files are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
// ========================
// Bench top
module pfci_host_tb;
  localparam [7:0] DEVC = 8'h3C; // Arbitrary value
  logic CORE_CLK_I = 1'b0;
  logic RESET_N_I = 1'b0;
  logic REQ_VALID_I = 1'b0;
  logic [3:0] REQ_OP_I = 4'h0;
  logic [16:0] REQ_ADDR_I = 17'h00000;
  logic [7:0] REQ_DATA_I = 8'h00;
  logic hang = 1'b0;
  wire REQ_READY_O, DONE_O, ERROR_O, ID_MODE_O, FL_DQ_OE_O;
  wire FL_CE_N_O, FL_OE_N_O, FL_WE_N_O;
  wire [16:0] FL_ADDR_O;
  wire [7:0] RDATA_O, FL_DQ_O, m_q;
  wire [7:0] FL_DQ_I = FL_DQ_OE_O ? FL_DQ_O : m_q; // Resolved bus
  int n_mismatch = 0, checks = 0, cyc = 0;
  integer seed = 67095;
  logic [7:0] sh [int];
  logic [16:0] a;
  always #10 CORE_CLK_I = ~CORE_CLK_I;
  // Short poll limit caps polling; the overrun case ends on the time-limit flag at the second read
  pfci_host #(.ADDR_W(17), .POLL_LIMIT(32'd40)) dut_u (
    .CORE_CLK_I, .RESET_N_I, .REQ_VALID_I, .REQ_OP_I, .REQ_ADDR_I,
    .REQ_DATA_I, .REQ_READY_O, .DONE_O, .RDATA_O, .ERROR_O, .ID_MODE_O,
    .FL_CE_N_O, .FL_OE_N_O, .FL_WE_N_O, .FL_ADDR_O, .FL_DQ_O,
    .FL_DQ_OE_O, .FL_DQ_I);
  pfci_fmodel #(.PSEC(5'h1F), .DEVC(DEVC)) m_u (
    .clk_i(CORE_CLK_I), .ce_n_i(FL_CE_N_O), .oe_n_i(FL_OE_N_O),
    .we_n_i(FL_WE_N_O), .hang_i(hang), .a_i(FL_ADDR_O),
    .d_i(FL_DQ_I), .q_o(m_q));
  // Comparison and verdict
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Writes on the bus and last byte written, per operation
  function automatic logic [15:0] ex_op(logic [3:0] o, logic [7:0] v);
    case (o)
      4'h1: ex_op = {8'h04, v};
      4'h2: ex_op = {8'h06, 8'h10};
      4'h3: ex_op = {8'h06, 8'h30};
      4'h4: ex_op = {8'h03, 8'h90};
      4'h5: ex_op = {8'h01, 8'hF0};
      4'h6: ex_op = {8'h01, 8'hB0};
      4'h7: ex_op = {8'h01, 8'h30};
      default: ex_op = 16'h0000;
    endcase
  endfunction
  function automatic logic [7:0] ex_rd(logic [16:0] ad);
    ex_rd = sh.exists(ad) ? sh[ad] : 8'hFF;
  endfunction
  task automatic step;
    @(posedge CORE_CLK_I);
    #1;
  endtask
  // One request held until taken, then wait for its completion
  task automatic op(input logic [3:0] o, input logic [16:0] ad,
    input logic [7:0] v);
    int w0;
    logic [15:0] e;
    w0 = m_u.n_wr;
    e = ex_op(o, v);
    REQ_OP_I = o;
    REQ_ADDR_I = ad;
    REQ_DATA_I = v;
    REQ_VALID_I = 1'b1;
    while (REQ_READY_O !== 1'b1) step();
    step();
    REQ_VALID_I = 1'b0;
    while (DONE_O !== 1'b1) step();
    chk(m_u.n_wr - w0, {24'h0, e[15:8]});
    if (o != 4'h0) chk(m_u.last_d, e[7:0]);
  endtask
  task automatic rd(input logic [16:0] ad, input logic [7:0] e);
    op(4'h0, ad, 8'h00);
    chk(RDATA_O, e);
  endtask
  // Cycle ceiling well above the 1200 or so cycles the sequence needs
  always @(posedge CORE_CLK_I) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge CORE_CLK_I);
    #1;
    RESET_N_I = 1'b1;
    rd(17'h0ABCD, 8'hFF);
    op(4'h1, 17'h01000, 8'h00);
    op(4'h1, 17'h02000, 8'h00);
    sh[17'h02000] = 8'h00;
    op(4'h3, 17'h01FFF, 8'h00);
    rd(17'h01000, 8'hFF);
    rd(17'h02000, 8'h00);
    op(4'h1, 17'h1F010, 8'h00);
    rd(17'h1F010, 8'hFF);
    for (int i = 0; i < 10; i++) begin
      a = 17'($random(seed)) & 17'h0FFFF;
      REQ_DATA_I = 8'($random(seed));
      sh[a] = ex_rd(a) & REQ_DATA_I;
      op(4'h1, a, REQ_DATA_I);
      rd(a, sh[a]);
    end
    op(4'h2, 17'h00000, 8'h00);
    sh.delete();
    rd(a, 8'hFF);
    op(4'h4, 17'h00000, 8'h00);
    chk(ID_MODE_O, 1'b1);
    rd(17'h00001, DEVC);
    rd(17'h1F002, 8'h01);
    rd(17'h03002, 8'h00);
    op(4'h5, 17'h00000, 8'h00);
    chk(ID_MODE_O, 1'b0);
    rd(17'h00001, 8'hFF);
    op(4'h6, 17'h12345, 8'h00);
    op(4'h7, 17'h0ABCD, 8'h00);
    hang = 1'b1;
    op(4'h1, 17'h00010, 8'h5A);
    chk(ERROR_O, 1'b1);
    hang = 1'b0;
    op(4'h5, 17'h00000, 8'h00);
    chk(ERROR_O, 1'b0);
    rd(17'h00010, 8'h5A);
    stop_test();
  end
endmodule // pfci_host_tb
`default_nettype wire
